/* common/dpc_pkg.sv */
// Defect pixel correction package: register map, fields, types
package dpc_pkg;
  // ************************************************************
  // Register byte addresses
  // ************************************************************
  localparam logic [31:0] CTRL_ADDR = 32'hf1000298;
  localparam logic [31:0] SIZE_ADDR = 32'hf100029c;
  localparam logic [31:0] THR_ADDR = 32'hf10002a0;
  localparam logic [31:0] DATA_ADDR = 32'hf10002a4;
  localparam logic [31:0] STAT_ADDR = 32'hf10002a8;
  localparam logic [31:0] MASK_ADDR = 32'hf10002ac;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int B_ON = 0;
  localparam int B_ERR = 1;
  localparam int B_BUILD = 2;
  localparam int B_SAVE = 3;
  localparam int B_LOAD = 4;
  localparam int B_UPL = 5;
  localparam int B_DNL = 6;
  localparam int MEAN_LO = 18;
  localparam int MEAN_W = 7;
  localparam int SIZE_LO = 4;
  localparam int SIZE_W = 14;
  localparam int THR_W = 8;
  // Interrupt event bits
  localparam int EV_BUILD = 0;
  localparam int EV_SAVE = 1;
  localparam int EV_LOAD = 2;
  localparam int EV_UPL = 3;
  localparam int EV_DNL = 4;
  localparam int EV_FMT = 5;
  localparam int EV_W = 6;
  // ************************************************************
  // Sizes, codes and reset values
  // ************************************************************
  localparam int RAM_DEPTH = 4096;
  localparam logic [11:0] MAX_CNT = 12'hfff;
  localparam logic [11:0] EE_HDR = 12'h000;
  localparam logic [7:0] THR_RESET = 8'h20;
  localparam logic [5:0] MASK_RESET = 6'h00;
  localparam logic [6:0] MEAN_SAT = 7'h7f;
  localparam logic [2:0] FMT_MONO_EIGHT_BIT_FORMAT = 3'h1;
  localparam logic [2:0] FMT_RAW_EIGHT_BIT_FORMAT = 3'h2;

  // One pixel of the video path
  typedef struct packed {
    logic sof;
    logic [15:0] y;
    logic [15:0] x;
    logic [7:0] data;
  } dpc_pix_type;

  // One stored defect entry
  typedef struct packed {
    logic [15:0] y;
    logic [15:0] x;
  } dpc_coord_type;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SUM, ST_MEAN, ST_SCAN,
    ST_SAVE_HDR, ST_SAVE_DATA, ST_LOAD_HDR, ST_LOAD_DATA
  } dpc_state_type;
endpackage

/* src/dpc_ctrl.sv */
// Defect pixel correction controller: build, store, transfer, apply

// Functional notes
// - Correction and building act only in 8-bit mono or 8-bit raw output format.
// - A correction request in any other format sets the error bit 1 of the control register.
// - A build computes one mean over every pixel of the captured frame.
// - A pixel is defective above mean plus threshold or below mean minus threshold.
// - Writing 1 to the build flag starts the search and stores each defect in the RAM until it holds 4095 entries.
// - Each entry is one word, y in bits 31 to 16 and x in bits 15 to 0.
// - After a build the mean appears in bits 24 to 18 of the control register.
// - The size field, bits 17 to 4, reads four times the number of entries.
// - The correction switch enables replacing listed pixels in the pixel path.
// - Writing 1 to the persist flag copies the whole list into the EEPROM.
// - Writing 1 to the restore flag copies the EEPROM list into the RAM.
// - After reset the EEPROM list is loaded into the RAM without a request.
// - Writing 1 to the upload flag lets the host read the list out of the RAM.
// - Writing 1 to the download flag lets the host write a new list into the RAM.
module dpc_ctrl #(
  parameter int FRAME_W = 640,
  parameter int FRAME_H = 480
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [31:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o,
  // Current output pixel format
  input wire logic [2:0] pixel_format_i,
  // Captured frame read port
  output logic [31:0] fb_addr_o,
  input wire logic [7:0] fb_data_i,
  // Pixel path
  input wire logic pix_valid_i,
  input wire dpc_pkg::dpc_pix_type pix_i,
  output logic pix_valid_o,
  output dpc_pkg::dpc_pix_type pix_o,
  // EEPROM word port
  output logic ee_req_o,
  output logic ee_we_o,
  output logic [11:0] ee_addr_o,
  output logic [31:0] ee_wdata_o,
  input wire logic ee_ack_i,
  input wire logic [31:0] ee_rdata_i
);
  localparam logic [31:0] NPIX = 32'(FRAME_W * FRAME_H);
  localparam logic [31:0] LAST_IDX = NPIX - 32'h1;
  localparam logic [15:0] LAST_X = 16'(FRAME_W - 1);

  // ************************************************************
  // Storage
  // ************************************************************
  dpc_pkg::dpc_state_type st_q;
  logic on_q, err_q, upl_q, dnl_q, boot_q;
  logic [7:0] thr_q, mean8_q;
  logic [6:0] mean_q;
  logic [11:0] cnt_q, tgt_q, eptr_q, xptr_q, ptr_q;
  logic [5:0] stat_q, mask_q, ev;
  logic [31:0] sum_q, idx_q, rdata_q, ctrl_rd, size_rd, rd_mux;
  logic run_q, dv_q;
  logic [15:0] x_q, y_q, dx_q, dy_q;
  logic [7:0] prev1_q, prev2_q;
  dpc_pkg::dpc_coord_type ram [dpc_pkg::RAM_DEPTH];
  logic ram_we;
  logic [11:0] ram_wa;
  dpc_pkg::dpc_coord_type ram_wd;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  // ************************************************************
  // Register decode
  // ************************************************************
  wire hit_ctrl = reg_addr_i == dpc_pkg::CTRL_ADDR;
  wire hit_size = reg_addr_i == dpc_pkg::SIZE_ADDR;
  wire hit_thr = reg_addr_i == dpc_pkg::THR_ADDR;
  wire hit_data = reg_addr_i == dpc_pkg::DATA_ADDR;
  wire hit_stat = reg_addr_i == dpc_pkg::STAT_ADDR;
  wire hit_mask = reg_addr_i == dpc_pkg::MASK_ADDR;
  wire wr_ctrl = reg_we_i & hit_ctrl;
  wire rd_stat = reg_re_i & hit_stat;
  wire wr_data = reg_we_i & hit_data;
  wire rd_data = reg_re_i & hit_data;

  // ************************************************************
  // Request qualification
  // ************************************************************
  // eligible formats
  wire fmt_ok = (pixel_format_i == dpc_pkg::FMT_MONO_EIGHT_BIT_FORMAT) | (pixel_format_i == dpc_pkg::FMT_RAW_EIGHT_BIT_FORMAT);
  wire is_raw = pixel_format_i == dpc_pkg::FMT_RAW_EIGHT_BIT_FORMAT;
  // Only one operation at a time; lower bit wins a combined write
  wire idle = (st_q == dpc_pkg::ST_IDLE) & ~upl_q & ~dnl_q;
  wire [6:0] wf = reg_wdata_i[6:0];
  wire req_build = wr_ctrl & wf[dpc_pkg::B_BUILD];
  wire req_save = wr_ctrl & wf[dpc_pkg::B_SAVE] & ~wf[dpc_pkg::B_BUILD];
  wire req_load = wr_ctrl & wf[dpc_pkg::B_LOAD] & (wf[3:2] == 2'h0);
  wire req_upl = wr_ctrl & wf[dpc_pkg::B_UPL] & (wf[4:2] == 3'h0);
  wire req_dnl = wr_ctrl & wf[dpc_pkg::B_DNL] & (wf[5:2] == 4'h0);
  wire start_build = idle & ~boot_q & req_build & fmt_ok;
  wire start_save = idle & ~boot_q & req_save;
  wire start_load = idle & (boot_q | req_load);
  wire start_upl = idle & ~boot_q & req_upl;
  wire start_dnl = idle & ~boot_q & req_dnl;
  wire end_dnl = dnl_q & wr_ctrl & ~wf[dpc_pkg::B_DNL];
  wire upl_last = upl_q & ((cnt_q == 12'h000) | (rd_data & (xptr_q == cnt_q - 12'h001)));
  wire fmt_bad = ~fmt_ok & ((wr_ctrl & (wf[dpc_pkg::B_ON] | wf[dpc_pkg::B_BUILD])) | on_q);
  wire room = cnt_q != dpc_pkg::MAX_CNT;
  wire dl_wr = wr_data & dnl_q & room;

  // ************************************************************
  // Frame walker
  // ************************************************************
  // The frame is assumed already captured when a build starts
  wire walk_go = start_build | (st_q == dpc_pkg::ST_MEAN);
  wire walk_end = dv_q & ~run_q;
  assign fb_addr_o = idx_q;

  // Address issue with one cycle read latency
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      run_q <= 1'b0;
      idx_q <= 32'h0;
      x_q <= 16'h0;
      y_q <= 16'h0;
      dv_q <= 1'b0;
      dx_q <= 16'h0;
      dy_q <= 16'h0;
    end else begin
      dv_q <= run_q;
      dx_q <= x_q;
      dy_q <= y_q;
      if (walk_go) begin
        run_q <= 1'b1;
        idx_q <= 32'h0;
        x_q <= 16'h0;
        y_q <= 16'h0;
      end else if (run_q) begin
        idx_q <= idx_q + 32'h1;
        run_q <= idx_q != LAST_IDX;
        x_q <= (x_q == LAST_X) ? 16'h0 : x_q + 16'h1;
        y_q <= (x_q == LAST_X) ? y_q + 16'h1 : y_q;
      end
    end
  end

  // ************************************************************
  // Defect classification
  // ************************************************************
  logic signed [9:0] pv, hi, lo;
  assign pv = {2'b00, fb_data_i};
  assign hi = {2'b00, mean8_q} + {2'b00, thr_q};
  assign lo = {2'b00, mean8_q} - {2'b00, thr_q};
  wire defect = (pv > hi) | (pv < lo);
  wire scan_wr = (st_q == dpc_pkg::ST_SCAN) & dv_q & defect & room;
  wire [31:0] quo = sum_q / NPIX;
  wire [6:0] mean_sat = (quo > 32'h7f) ? dpc_pkg::MEAN_SAT : quo[6:0];

  // ************************************************************
  // EEPROM sequencing terms
  // ************************************************************
  wire ee_go = ee_req_o & ee_ack_i;
  wire hdr_ok = (ee_rdata_i != 32'h0) & (ee_rdata_i <= {20'h0, dpc_pkg::MAX_CNT});
  wire save_last = (st_q == dpc_pkg::ST_SAVE_DATA) & ee_go & (eptr_q == cnt_q - 12'h001);
  wire load_last = (st_q == dpc_pkg::ST_LOAD_DATA) & ee_go & (eptr_q == tgt_q - 12'h001);

  // ************************************************************
  // List RAM
  // ************************************************************
  // Write source select; sources never overlap in time
  always_comb begin
    ram_we = 1'b1;
    ram_wa = cnt_q;
    ram_wd = reg_wdata_i;
    if (scan_wr) begin
      ram_wd = {dy_q, dx_q};
    end else if ((st_q == dpc_pkg::ST_LOAD_DATA) & ee_go) begin
      ram_wa = eptr_q;
      ram_wd = ee_rdata_i;
    end else if (!dl_wr) begin
      ram_we = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (ram_we) begin
      ram[ram_wa] <= ram_wd;
    end
  end

  // List length; a build or a download replaces the list
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cnt_q <= 12'h000;
    end else if ((st_q == dpc_pkg::ST_MEAN) | start_dnl) begin
      cnt_q <= 12'h000;
    end else if (scan_wr | dl_wr) begin
      cnt_q <= cnt_q + 12'h001;
    end else if (load_last) begin
      cnt_q <= tgt_q;
    end
  end

  // ************************************************************
  // Operation sequencer
  // ************************************************************
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_q <= dpc_pkg::ST_IDLE;
      sum_q <= 32'h0;
      mean8_q <= 8'h00;
      mean_q <= 7'h00;
      ee_req_o <= 1'b0;
      ee_we_o <= 1'b0;
      ee_addr_o <= 12'h000;
      ee_wdata_o <= 32'h0;
      eptr_q <= 12'h000;
      tgt_q <= 12'h000;
      boot_q <= 1'b1;
    end else begin
      unique case (st_q)
        dpc_pkg::ST_IDLE: begin
          if (start_build) begin
            st_q <= dpc_pkg::ST_SUM;
            sum_q <= 32'h0;
          end else if (start_save) begin
            st_q <= dpc_pkg::ST_SAVE_HDR;
            ee_req_o <= 1'b1;
            ee_we_o <= 1'b1;
            ee_addr_o <= dpc_pkg::EE_HDR;
            ee_wdata_o <= {20'h0, cnt_q};
          end else if (start_load) begin
            st_q <= dpc_pkg::ST_LOAD_HDR;
            ee_req_o <= 1'b1;
            ee_we_o <= 1'b0;
            ee_addr_o <= dpc_pkg::EE_HDR;
            boot_q <= 1'b0;
          end
        end
        dpc_pkg::ST_SUM: begin
          if (dv_q) begin
            sum_q <= sum_q + {24'h0, fb_data_i};
          end
          if (walk_end) begin
            st_q <= dpc_pkg::ST_MEAN;
          end
        end
        dpc_pkg::ST_MEAN: begin
          // mean field, saturated to its width
          mean8_q <= quo[7:0];
          mean_q <= mean_sat;
          st_q <= dpc_pkg::ST_SCAN;
        end
        dpc_pkg::ST_SCAN: begin
          if (walk_end) begin
            st_q <= dpc_pkg::ST_IDLE;
          end
        end
        dpc_pkg::ST_SAVE_HDR: begin
          if (ee_go && cnt_q == 12'h000) begin
            st_q <= dpc_pkg::ST_IDLE;
            ee_req_o <= 1'b0;
          end else if (ee_go) begin
            st_q <= dpc_pkg::ST_SAVE_DATA;
            eptr_q <= 12'h000;
            ee_addr_o <= dpc_pkg::EE_HDR + 12'h001;
            ee_wdata_o <= ram[0];
          end
        end
        dpc_pkg::ST_SAVE_DATA: begin
          if (save_last) begin
            st_q <= dpc_pkg::ST_IDLE;
            ee_req_o <= 1'b0;
          end else if (ee_go) begin
            eptr_q <= eptr_q + 12'h001;
            ee_addr_o <= ee_addr_o + 12'h001;
            ee_wdata_o <= ram[eptr_q + 12'h001];
          end
        end
        dpc_pkg::ST_LOAD_HDR: begin
          // An erased or empty header leaves the list unchanged
          if (ee_go && !hdr_ok) begin
            st_q <= dpc_pkg::ST_IDLE;
            ee_req_o <= 1'b0;
          end else if (ee_go) begin
            st_q <= dpc_pkg::ST_LOAD_DATA;
            tgt_q <= ee_rdata_i[11:0];
            eptr_q <= 12'h000;
            ee_addr_o <= dpc_pkg::EE_HDR + 12'h001;
          end
        end
        dpc_pkg::ST_LOAD_DATA: begin
          if (load_last) begin
            st_q <= dpc_pkg::ST_IDLE;
            ee_req_o <= 1'b0;
          end else if (ee_go) begin
            eptr_q <= eptr_q + 12'h001;
            ee_addr_o <= ee_addr_o + 12'h001;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Software registers
  // ************************************************************
  // busy flags read back
  always_comb begin
    ctrl_rd = 32'h0;
    ctrl_rd[dpc_pkg::B_ON] = on_q;
    ctrl_rd[dpc_pkg::B_ERR] = err_q;
    ctrl_rd[dpc_pkg::B_BUILD] = (st_q == dpc_pkg::ST_SUM) | (st_q == dpc_pkg::ST_MEAN) | (st_q == dpc_pkg::ST_SCAN);
    ctrl_rd[dpc_pkg::B_SAVE] = (st_q == dpc_pkg::ST_SAVE_HDR) | (st_q == dpc_pkg::ST_SAVE_DATA);
    ctrl_rd[dpc_pkg::B_LOAD] = (st_q == dpc_pkg::ST_LOAD_HDR) | (st_q == dpc_pkg::ST_LOAD_DATA);
    ctrl_rd[dpc_pkg::B_UPL] = upl_q;
    ctrl_rd[dpc_pkg::B_DNL] = dnl_q;
    ctrl_rd[dpc_pkg::MEAN_LO +: dpc_pkg::MEAN_W] = mean_q;
    // size is four times the count
    size_rd = 32'h0;
    size_rd[dpc_pkg::SIZE_LO +: dpc_pkg::SIZE_W] = {cnt_q, 2'b00};
  end

  assign rd_mux = hit_ctrl ? ctrl_rd :
                  hit_size ? size_rd :
                  hit_thr ? {24'h0, thr_q} :
                  hit_data ? ram[xptr_q] :
                  hit_stat ? {26'h0, stat_q} :
                  hit_mask ? {26'h0, mask_q} : 32'h0;
  assign reg_rdata_o = rdata_q;

  // Completion and error events
  always_comb begin
    ev = 6'h00;
    ev[dpc_pkg::EV_BUILD] = (st_q == dpc_pkg::ST_SCAN) & walk_end;
    ev[dpc_pkg::EV_SAVE] = save_last | ((st_q == dpc_pkg::ST_SAVE_HDR) & ee_go & (cnt_q == 12'h000));
    ev[dpc_pkg::EV_LOAD] = load_last | ((st_q == dpc_pkg::ST_LOAD_HDR) & ee_go & ~hdr_ok);
    ev[dpc_pkg::EV_UPL] = upl_last;
    ev[dpc_pkg::EV_DNL] = end_dnl;
    ev[dpc_pkg::EV_FMT] = fmt_bad & ~err_q;
  end

  // Sticky status: a new event beats the read that clears
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      on_q <= 1'b0;
      err_q <= 1'b0;
      thr_q <= dpc_pkg::THR_RESET;
      mask_q <= dpc_pkg::MASK_RESET;
      stat_q <= 6'h00;
      upl_q <= 1'b0;
      dnl_q <= 1'b0;
      xptr_q <= 12'h000;
      rdata_q <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        on_q <= wf[dpc_pkg::B_ON];
      end
      err_q <= fmt_bad | (err_q & ~(wr_ctrl & wf[dpc_pkg::B_ERR]));
      if (reg_we_i & hit_thr) begin
        thr_q <= reg_wdata_i[dpc_pkg::THR_W-1:0];
      end
      if (reg_we_i & hit_mask) begin
        mask_q <= reg_wdata_i[dpc_pkg::EV_W-1:0];
      end
      stat_q <= (rd_stat ? 6'h00 : stat_q) | ev;
      upl_q <= start_upl | (upl_q & ~upl_last);
      xptr_q <= start_upl ? 12'h000 : xptr_q + {11'h0, upl_q & rd_data};
      dnl_q <= start_dnl | (dnl_q & ~end_dnl);
      if (reg_re_i) begin
        rdata_q <= rd_mux;
      end
    end
  end
  assign irq_o = |(stat_q & mask_q);

  // ************************************************************
  // Correction in the pixel path
  // ************************************************************
  // The list must be in raster order; an entry out of order is skipped along with every entry after it
  wire [11:0] ptr_eff = pix_i.sof ? 12'h000 : ptr_q;
  dpc_pkg::dpc_coord_type entry;
  assign entry = ram[ptr_eff];
  // replace listed pixels when switched on
  wire match = pix_valid_i & on_q & fmt_ok & (ptr_eff < cnt_q) & (entry.x == pix_i.x) & (entry.y == pix_i.y);
  // Raw data takes the nearest same-colour neighbour
  wire [7:0] repl = is_raw ? prev2_q : prev1_q;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pix_valid_o <= 1'b0;
      pix_o <= '0;
      ptr_q <= 12'h000;
      prev1_q <= 8'h00;
      prev2_q <= 8'h00;
    end else begin
      pix_valid_o <= pix_valid_i;
      if (pix_valid_i) begin
        pix_o <= match ? {pix_i.sof, pix_i.y, pix_i.x, repl} : pix_i;
        prev1_q <= pix_i.data;
        prev2_q <= prev1_q;
        ptr_q <= ptr_eff + {11'h0, match};
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_build_go;
    start_build;
  endsequence
  sequence s_summing;
    (st_q == dpc_pkg::ST_SUM) && ctrl_rd[dpc_pkg::B_BUILD];
  endsequence
  sequence s_scan_done;
    (st_q == dpc_pkg::ST_SCAN) ##1 (st_q == dpc_pkg::ST_IDLE);
  endsequence
  property p_build_start;
    s_build_go |=> s_summing;
  endproperty
  a_build_start: assert property (p_build_start) else $error("build did not start");
  property p_mean;
    st_q == dpc_pkg::ST_MEAN |=> mean8_q == 8'($past(sum_q) / NPIX) && cnt_q == 12'h000;
  endproperty
  a_mean: assert property (p_mean) else $error("frame mean wrong");
  property p_mean_field;
    s_scan_done |-> ctrl_rd[dpc_pkg::MEAN_LO +: dpc_pkg::MEAN_W] == mean_q &&
      mean_q == (mean8_q[7] ? dpc_pkg::MEAN_SAT : mean8_q[6:0]);
  endproperty
  a_mean_field: assert property (p_mean_field) else $error("mean field wrong");
  property p_defect;
    scan_wr |-> ram_we && ram_wd == {dy_q, dx_q} ##1 cnt_q == $past(cnt_q) + 12'h001;
  endproperty
  a_defect: assert property (p_defect) else $error("defect not stored");
  property p_size;
    reg_re_i && hit_size |=> reg_rdata_o[dpc_pkg::SIZE_LO +: dpc_pkg::SIZE_W] == {$past(cnt_q), 2'b00};
  endproperty
  a_size: assert property (p_size) else $error("size field wrong");
  property p_err;
    wr_ctrl && wf[dpc_pkg::B_ON] && !fmt_ok |=> ctrl_rd[dpc_pkg::B_ERR];
  endproperty
  a_err: assert property (p_err) else $error("format error not flagged");
  property p_nofix;
    pix_valid_i && !fmt_ok |=> pix_valid_o && pix_o == $past(pix_i);
  endproperty
  a_nofix: assert property (p_nofix) else $error("pixel altered in other format");
  property p_fix;
    match && !is_raw |=> pix_o.data == $past(prev1_q);
  endproperty
  a_fix: assert property (p_fix) else $error("listed pixel not replaced");
  property p_save;
    start_save |=> ee_req_o && ee_we_o && ee_addr_o == dpc_pkg::EE_HDR && ee_wdata_o[11:0] == $past(cnt_q);
  endproperty
  a_save: assert property (p_save) else $error("persist header wrong");
  property p_boot;
    boot_q && idle && rst_n_i |=> st_q == dpc_pkg::ST_LOAD_HDR && !boot_q;
  endproperty
  a_boot: assert property (p_boot) else $error("boot restore missing");
  property p_upl;
    rd_data && upl_q |=> reg_rdata_o == $past(ram[xptr_q]);
  endproperty
  a_upl: assert property (p_upl) else $error("upload word wrong");
  property p_dnl;
    dl_wr |-> ram_we && ram_wa == cnt_q ##1 cnt_q == $past(cnt_q) + 12'h001;
  endproperty
  a_dnl: assert property (p_dnl) else $error("download word lost");
endmodule // dpc_ctrl

/* verif/defect_pixel_correction_ctrl_test.sv */
// Self-checking bench for the defect pixel controller
module defect_pixel_correction_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [31:0] reg_addr_i = 32'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic chk_q = 1'b0;
  logic chk_d = 1'b0;
  logic pix_valid_i = 1'b0;
  logic [2:0] pixel_format_i = 3'h1;
  logic [7:0] fb_data_i = 8'h0;
  dpc_pkg::dpc_pix_type pix_i = '0;
  dpc_pkg::dpc_pix_type pix_o;
  logic [31:0] reg_rdata_o, fb_addr_o, ee_wdata_o, ee_rdata_i, v;
  logic irq_o, pix_valid_o, ee_req_o, ee_we_o, ee_ack_i;
  logic [11:0] ee_addr_o;
  logic [7:0] frame [0:31];
  logic [31:0] exp_q[$], msk_q[$], pix_q[$];
  integer errors = 0, cmp_count = 0, seed = 90, sum = 0;

  always #20 clock_i = ~clock_i;

  dpc_ctrl #(.FRAME_W(8), .FRAME_H(4)) u_dut (.clock_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
    .reg_we_i, .reg_re_i, .reg_rdata_o, .irq_o, .pixel_format_i, .fb_addr_o, .fb_data_i,
    .pix_valid_i, .pix_i, .pix_valid_o, .pix_o, .ee_req_o, .ee_we_o, .ee_addr_o, .ee_wdata_o,
    .ee_ack_i, .ee_rdata_i);
  dpc_ee_model u_ee (.clock_i, .rst_n_i, .ee_req_i(ee_req_o), .ee_we_i(ee_we_o),
    .ee_addr_i(ee_addr_o), .ee_wdata_i(ee_wdata_o), .ee_ack_o(ee_ack_i), .ee_rdata_o(ee_rdata_i));

  // Captured frame answers one cycle after its address
  always @(posedge clock_i) fb_data_i <= frame[fb_addr_o[4:0]];

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Oldest note against each result as it appears
  always @(posedge clock_i) begin
    chk_d <= chk_q && reg_re_i;
    if (chk_d) check("reg", reg_rdata_o & msk_q.pop_front(), exp_q.pop_front());
    if (pix_valid_o) check("pix", {24'h0, pix_o.data}, pix_q.pop_front());
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_we_i <= 1'b0;
  endtask

  // Read data stands in the cycle after the strobe and holds
  task automatic rd(input logic [31:0] a, input logic c);
    @(posedge clock_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    chk_q <= c;
    @(posedge clock_i);
    reg_re_i <= 1'b0;
    @(posedge clock_i);
    v = reg_rdata_o;
  endtask

  task automatic note_rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    exp_q.push_back(e);
    msk_q.push_back(m);
    rd(a, 1'b1);
  endtask

  // Poll a busy flag under a bound
  task automatic wait_clear(input int b);
    for (int n = 0; n < 200; n++) begin
      rd(dpc_pkg::CTRL_ADDR, 1'b0);
      if (v[b] === 1'b0) return;
    end
    errors++;
    test_done();
  endtask

  // Back is how far behind the replacement lies, 0 for no replacement
  task automatic stream(input int back);
    for (int k = 0; k < 32; k++) begin
      @(posedge clock_i);
      pix_valid_i <= 1'b1;
      pix_i <= {k == 0, 16'(k / 8), 16'(k % 8), frame[k]};
      pix_q.push_back(32'(back > 0 && (k == 11 || k == 21) ? frame[k - back] : frame[k]));
    end
    @(posedge clock_i);
    pix_valid_i <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask

  initial begin
    // Dark frame, flat with one hot and one cold pixel
    for (int i = 0; i < 32; i++) begin
      frame[i] = i == 11 ? 8'hff : i == 21 ? 8'h00 : 8'h40 + 8'($random(seed) & 3);
      sum += frame[i];
    end
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    // Stored list comes back without a request
    wait_clear(dpc_pkg::B_LOAD);
    note_rd(dpc_pkg::SIZE_ADDR, 32'h3fff0, 32'h40);
    note_rd(dpc_pkg::THR_ADDR, 32'hff, 32'h20);
    $display("boot test done");
    // No binning or sub-sampling is used, so no mode select comes first
    // Ineligible format flags instead of building
    pixel_format_i <= 3'h0;
    wr(dpc_pkg::CTRL_ADDR, 32'h5);
    note_rd(dpc_pkg::CTRL_ADDR, 32'h6, 32'h2);
    pixel_format_i <= 3'h1;
    wr(dpc_pkg::CTRL_ADDR, 32'h2);
    note_rd(dpc_pkg::CTRL_ADDR, 32'h7, 32'h0);
    $display("format test done");
    // Build with the done event unmasked
    wr(dpc_pkg::MASK_ADDR, 32'h1);
    wr(dpc_pkg::CTRL_ADDR, 32'h4);
    wait_clear(dpc_pkg::B_BUILD);
    note_rd(dpc_pkg::CTRL_ADDR, 32'h01fc0000, 32'(sum / 32 > 127 ? 127 : sum / 32) << 18);
    note_rd(dpc_pkg::SIZE_ADDR, 32'h3fff0, 32'h80);
    check("irq", {31'h0, irq_o}, 32'h1);
    note_rd(dpc_pkg::STAT_ADDR, 32'h1, 32'h1);
    check("irq", {31'h0, irq_o}, 32'h0);
    $display("build test done");
    // Persist, then overwrite by download, then restore
    wr(dpc_pkg::CTRL_ADDR, 32'h8);
    wait_clear(dpc_pkg::B_SAVE);
    check("ee", u_ee.mem[0], 32'h2);
    check("ee", u_ee.mem[2], 32'h00020005);
    wr(dpc_pkg::CTRL_ADDR, 32'h40);
    wr(dpc_pkg::DATA_ADDR, 32'h00030001);
    wr(dpc_pkg::CTRL_ADDR, 32'h0);
    note_rd(dpc_pkg::SIZE_ADDR, 32'h3fff0, 32'h40);
    wr(dpc_pkg::CTRL_ADDR, 32'h10);
    wait_clear(dpc_pkg::B_LOAD);
    note_rd(dpc_pkg::SIZE_ADDR, 32'h3fff0, 32'h80);
    $display("store test done");
    wr(dpc_pkg::CTRL_ADDR, 32'h20);
    note_rd(dpc_pkg::DATA_ADDR, 32'hffffffff, 32'h00010003);
    note_rd(dpc_pkg::DATA_ADDR, 32'hffffffff, 32'h00020005);
    wait_clear(dpc_pkg::B_UPL);
    $display("upload test done");
    // Listed pixels replaced only while switched on; raw takes two back
    wr(dpc_pkg::CTRL_ADDR, 32'h1);
    stream(1);
    pixel_format_i <= 3'h2;
    stream(2);
    // Ineligible format passes pixels untouched and flags
    pixel_format_i <= 3'h0;
    stream(0);
    note_rd(dpc_pkg::CTRL_ADDR, 32'h3, 32'h3);
    pixel_format_i <= 3'h1;
    wr(dpc_pkg::CTRL_ADDR, 32'h2);
    stream(0);
    check("pix left", pix_q.size(), 32'h0);
    $display("pixel test done");
    test_done();
  end
endmodule // defect_pixel_correction_ctrl_test

/* verif/dpc_ee_model.sv */
// Word-wide EEPROM model that holds the stored defect list
module dpc_ee_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Word port
  input wire logic ee_req_i,
  input wire logic ee_we_i,
  input wire logic [11:0] ee_addr_i,
  input wire logic [31:0] ee_wdata_i,
  output logic ee_ack_o,
  output logic [31:0] ee_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:4095];
  logic [1:0] wait_q;
  // One stored entry so the boot load has work
  initial begin
    ee_ack_o = 1'b0;
    ee_rdata_o = 32'h0;
    mem[0] = 32'h1;
    mem[1] = 32'h00020006;
  end
  // store words, latency varies by address
  always @(posedge clock_i) begin
    if (!rst_n_i || ee_ack_o || !ee_req_i) begin
      ee_ack_o <= 1'b0;
      wait_q <= ee_addr_i[1:0];
      // Idle data keeps changing so a stale read cannot pass
      ee_rdata_o <= ~ee_rdata_o;
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else begin
      ee_ack_o <= 1'b1;
      if (ee_we_i) begin
        mem[ee_addr_i] <= ee_wdata_i;
      end
      ee_rdata_o <= mem[ee_addr_i];
    end
  end
endmodule // dpc_ee_model
